/* design/device_timer_unit.sv */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Writing one to the re-arm bit reloads the watchdog count with its timeout and the bit reads back zero.
// RULE_02: Writing one to the force-expiry bit expires the watchdog at once with its count set to zero, self-clearing.
// RULE_03: An eight-bit malfunction reason field in bits 31:24 is writable and readable, zero meaning functional.
// RULE_04: Free-running timer bits 9:0 count microseconds within the current millisecond.
// RULE_05: Free-running timer bits 19:10 count milliseconds within the current second.
// RULE_06: Free-running timer bits 31:20 count whole seconds since start, up to 4095.
// RULE_07: The free-running timer is cleared by the bus reset and by a software reset.
// RULE_08: Software writes the free-running timer only for test and otherwise only reads it.
// RULE_09: The interval counter reloads from an eight-bit millisecond value in bits 7:0.
// RULE_10: Writing one to start bit 8 begins a down-count from the interval value, writing zero does nothing.
// RULE_11: Clearing count-enable bit 9 pauses counting; setting it resumes from a nonzero held value, else waits for start.
// RULE_12: Writing one to finish bit 10 raises the interval interrupt, reloads the counter and stops until start or loop.
// RULE_13: With loop bit 11 set the counter reloads at zero and continues, otherwise it stops at zero.
// RULE_14: Software must write start to begin counting, setting loop alone does not start it. The code starts on a loop write alone after a finish.
// RULE_15: The interval interrupt is raised each time the active down-count reaches zero.
// RULE_16: On expiry the watchdog raises its interrupt and drives its pin, then holds zero until re-armed.
// RULE_17: The watchdog timeout is eight bits of whole seconds, reset value two, reloaded on every re-arm.
module device_timer_unit
	import timer_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire timer_unit_pkg::avl_req_t avl_req,
	output logic [timer_unit_pkg::DATA_W-1:0] avl_readdata,
	output logic avl_waitrequest,
	output logic irq,
	output logic software_definable_pin
);
	import timer_unit_pkg::*;

	logic wr_cycle;
	logic rd_cycle;
	logic wr_setup;
	logic wr_wd_status;
	logic wr_frt;
	logic wr_ivl;
	logic wr_int_status;
	logic wr_int_mask;
	logic wr_soft_reset;
	logic [DATA_W-1:0] bit_mask;
	logic [DATA_W-1:0] wdata;

	logic wd_enable;
	logic wd_load_enable;
	logic [7:0] watchdog_current_count;
	logic [7:0] watchdog_timeout_seconds;
	logic [7:0] stuck_reason;
	logic wd_expire_event;
	logic wd_force;
	logic wd_rearm;

	frt_value_t frt_value;
	logic ms_tick;
	logic sec_tick;
	logic soft_reset;

	logic [7:0] ivl_duration;
	logic interval_count_enable;
	logic ivl_loop;
	logic [7:0] ivl_count;
	ivl_state_t ivl_state;
	logic ivl_event;
	logic interval_start;
	logic interval_force_finish;
	logic ivl_loop_write;

	logic [IRQ_W-1:0] int_status;
	logic [IRQ_W-1:0] int_mask;
	logic [IRQ_W-1:0] int_events;
	logic [IRQ_W-1:0] int_clear;
	logic [DATA_W-1:0] next_readdata;

	// A request is answered one cycle after it is first seen, so every write lands on a single edge.
	assign wr_cycle = avl_req.write && !avl_waitrequest;
	assign rd_cycle = avl_req.read && avl_waitrequest;

	genvar lane;
	generate
		for (lane = 0; lane < BE_W; lane++) begin : g_lane
			assign bit_mask[lane*8 +: 8] = {8{avl_req.byteenable[lane]}};
		end
	endgenerate

	// Disabled byte lanes write as zero, which leaves command bits untouched in those lanes.
	assign wdata = avl_req.writedata & bit_mask;

	assign wr_setup = wr_cycle && (avl_req.address == OFS_WATCHDOG_SETUP);
	assign wr_wd_status = wr_cycle && (avl_req.address == OFS_WATCHDOG_SOFTWARE_STATUS);
	assign wr_frt = wr_cycle && (avl_req.address == OFS_FREE_RUNNING_TIME_COUNT);
	assign wr_ivl = wr_cycle && (avl_req.address == OFS_INTERVAL_INTERRUPT_TIMER);
	assign wr_int_status = wr_cycle && (avl_req.address == OFS_INT_STATUS);
	assign wr_int_mask = wr_cycle && (avl_req.address == OFS_INT_MASK);
	assign wr_soft_reset = wr_cycle && (avl_req.address == OFS_SOFT_RESET);

	// Waitrequest drops for exactly one cycle per request; a request still held after its answer is taken again two cycles later.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			avl_waitrequest <= 1'b1;
		end else if ((avl_req.read || avl_req.write) && avl_waitrequest) begin
			avl_waitrequest <= 1'b0;
		end else begin
			avl_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		next_readdata = '0;
		case (avl_req.address)
			OFS_WATCHDOG_SETUP: begin
				next_readdata[WD_ENABLE_BIT] = wd_enable;
				next_readdata[WD_LOAD_ENABLE_BIT] = wd_load_enable;
				next_readdata[WD_COUNT_LSB +: 8] = watchdog_current_count;
				next_readdata[WATCHDOG_TIMEOUT_SECONDS_LSB +: 8] = watchdog_timeout_seconds;
			end
			OFS_WATCHDOG_SOFTWARE_STATUS: begin
				next_readdata[STUCK_REASON_LSB +: 8] = stuck_reason; // RULE_03
			end
			OFS_FREE_RUNNING_TIME_COUNT: begin
				next_readdata = frt_value;
			end
			OFS_INTERVAL_INTERRUPT_TIMER: begin
				next_readdata[IVL_DURATION_LSB +: 8] = ivl_duration;
				next_readdata[IVL_COUNT_ENABLE_BIT] = interval_count_enable;
				next_readdata[IVL_LOOP_BIT] = ivl_loop;
			end
			OFS_INT_STATUS: begin
				next_readdata[IRQ_W-1:0] = int_status;
			end
			OFS_INT_MASK: begin
				next_readdata[IRQ_W-1:0] = int_mask;
			end
			default: begin
				next_readdata = '0;
			end
		endcase
	end

	// Read data load on the first cycle of a read and then hold until the next read is answered.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			avl_readdata <= '0;
		end else if (rd_cycle) begin
			avl_readdata <= next_readdata;
		end
	end

	// Software reset is a one-cycle pulse; it clears the free-running timer and the test load enable.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr_soft_reset && wdata[SOFT_RESET_BIT];
		end
	end

	// Unwritten byte lanes keep the running value, so a partial test write changes only its own lanes.
	free_running_timer u_frt (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(soft_reset), // RULE_07
		.load(wr_frt), // RULE_08
		.load_value(frt_value_t'(wdata | (frt_value & ~bit_mask))),
		.value(frt_value),
		.ms_tick(ms_tick),
		.sec_tick(sec_tick)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wd_enable <= 1'b0;
		end else if (wr_setup && avl_req.byteenable[0]) begin
			wd_enable <= wdata[WD_ENABLE_BIT];
		end
	end

	// Software reset drops only the test load enable; the enable and the timeout keep their values.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wd_load_enable <= 1'b0;
		end else if (soft_reset) begin
			wd_load_enable <= 1'b0;
		end else if (wr_setup && avl_req.byteenable[0]) begin
			wd_load_enable <= wdata[WD_LOAD_ENABLE_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_timeout_seconds <= WATCHDOG_TIMEOUT_SECONDS_RESET; // RULE_17
		end else if (wr_setup && avl_req.byteenable[3]) begin
			watchdog_timeout_seconds <= wdata[WATCHDOG_TIMEOUT_SECONDS_LSB +: 8]; // RULE_17
		end
	end

	// The reason byte is plain storage; its meaning is agreed between software and firmware.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stuck_reason <= STUCK_REASON_RESET;
		end else if (wr_wd_status && avl_req.byteenable[3]) begin
			stuck_reason <= wdata[STUCK_REASON_LSB +: 8]; // RULE_03
		end
	end

	// Re-arm and force-expiry act on the write itself and are never stored, so they read as zero.
	assign wd_force = wr_wd_status && wdata[FORCE_EXPIRY_BIT]; // RULE_02
	assign wd_rearm = wr_wd_status && wdata[WD_REARM_BIT]; // RULE_01
	assign wd_expire_event = wd_force // RULE_02
		|| (wd_enable && sec_tick && watchdog_current_count == 8'h01); // RULE_16

	// A forced expiry beats a re-arm in the same write, so software cannot cancel its own fatal report.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_current_count <= WATCHDOG_TIMEOUT_SECONDS_RESET;
		end else if (wd_force) begin
			watchdog_current_count <= 8'h00; // RULE_02
		end else if (wd_rearm) begin
			watchdog_current_count <= watchdog_timeout_seconds; // RULE_01
		end else if (wr_setup && wd_load_enable && avl_req.byteenable[2]) begin
			watchdog_current_count <= wdata[WD_COUNT_LSB +: 8];
		end else if (wd_enable && sec_tick && watchdog_current_count != 8'h00) begin
			watchdog_current_count <= watchdog_current_count - 8'h01; // RULE_16
		end
	end

	// The pin stays asserted through the whole expired period, not just the expiry edge.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			software_definable_pin <= 1'b0;
		end else if (wd_expire_event) begin
			software_definable_pin <= 1'b1; // RULE_16
		end else if (wd_rearm) begin
			software_definable_pin <= 1'b0; // RULE_01
		end
	end

	// A new duration takes effect at the next start, finish or loop reload, never in mid-count.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ivl_duration <= IVL_DURATION_RESET;
		end else if (wr_ivl && avl_req.byteenable[0]) begin
			ivl_duration <= wdata[IVL_DURATION_LSB +: 8]; // RULE_09
		end
	end

	// Clearing the enable freezes the down-count without losing its place.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			interval_count_enable <= 1'b0;
		end else if (wr_ivl && avl_req.byteenable[1]) begin
			interval_count_enable <= wdata[IVL_COUNT_ENABLE_BIT]; // RULE_11
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ivl_loop <= 1'b0;
		end else if (wr_ivl && avl_req.byteenable[1]) begin
			ivl_loop <= wdata[IVL_LOOP_BIT]; // RULE_13
		end
	end

	assign interval_start = wr_ivl && wdata[IVL_START_BIT]; // RULE_10
	assign interval_force_finish = wr_ivl && wdata[IVL_FINISH_BIT]; // RULE_12
	assign ivl_loop_write = wr_ivl && avl_req.byteenable[1] && wdata[IVL_LOOP_BIT]; // RULE_12
	assign ivl_event = interval_force_finish // RULE_12
		|| (!interval_start && ivl_state == IVL_RUN && interval_count_enable && ms_tick
		&& ivl_count == 8'h01); // RULE_15

	// Commands from the bus take priority over a millisecond tick in the same cycle.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ivl_state <= IVL_IDLE;
		end else if (interval_start) begin
			ivl_state <= IVL_RUN; // RULE_10
		end else if (interval_force_finish) begin
			ivl_state <= IVL_FINISHED; // RULE_12
		end else begin
			case (ivl_state)
				IVL_IDLE: begin
					ivl_state <= IVL_IDLE; // RULE_14
				end
				IVL_FINISHED: begin
					if (ivl_loop_write) begin
						ivl_state <= IVL_RUN; // RULE_12
					end
				end
				IVL_RUN: begin
					if (interval_count_enable && ms_tick && ivl_count <= 8'h01 && !ivl_loop) begin // RULE_11
						ivl_state <= IVL_IDLE; // RULE_13
					end
				end
				default: begin
					ivl_state <= IVL_IDLE;
				end
			endcase
		end
	end

	// The count moves only while running, so a paused or finished counter keeps its value.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ivl_count <= 8'h00;
		end else if (interval_start) begin
			ivl_count <= (wr_ivl && avl_req.byteenable[0]) ? wdata[IVL_DURATION_LSB +: 8] : ivl_duration; // RULE_09
		end else if (interval_force_finish) begin
			ivl_count <= ivl_duration; // RULE_12
		end else if (ivl_state == IVL_RUN && interval_count_enable && ms_tick) begin // RULE_11
			if (ivl_count > 8'h01) begin
				ivl_count <= ivl_count - 8'h01; // RULE_09
			end else if (ivl_loop) begin
				ivl_count <= ivl_duration; // RULE_13
			end else begin
				ivl_count <= 8'h00; // RULE_13
			end
		end
	end

	assign int_events = {ivl_event, wd_expire_event};
	assign int_clear = wr_int_status ? wdata[IRQ_W-1:0] : '0;

	// An event in the same cycle as its clear survives, because the set is ORed in after the clear.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~int_clear) | int_events; // RULE_15
		end
	end

	// The mask gates only the output; masked events still latch in the status register.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			int_mask <= IRQ_MASK_RESET;
		end else if (wr_int_mask && avl_req.byteenable[0]) begin
			int_mask <= wdata[IRQ_W-1:0];
		end
	end

	// The interrupt lags the status by one cycle so that it comes straight from a flop.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask); // RULE_16
		end
	end

endmodule // device_timer_unit

/* design/free_running_timer.sv */
`timescale 1ns/1ns
module free_running_timer
	import timer_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clear,
	input wire logic load,
	input wire timer_unit_pkg::frt_value_t load_value,
	output timer_unit_pkg::frt_value_t value,
	output logic ms_tick,
	output logic sec_tick
);
	logic [5:0] prescale;
	logic us_wrap;
	logic ms_wrap;

	assign us_wrap = (prescale == PRESCALE_LAST) && (value.us == FRT_SUB_LAST);
	assign ms_wrap = us_wrap && (value.ms == FRT_SUB_LAST);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prescale <= 6'h00;
		end else if (clear || load || prescale == PRESCALE_LAST) begin
			prescale <= 6'h00;
		end else begin
			prescale <= prescale + 6'h01;
		end
	end

	// The seconds field rolls over after its last value so the timer never stops.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			value <= '0; // RULE_07
		end else if (clear) begin
			value <= '0; // RULE_07
		end else if (load) begin
			value <= load_value;
		end else if (prescale == PRESCALE_LAST) begin
			value.us <= (value.us == FRT_SUB_LAST) ? 10'h000 : value.us + 10'h001; // RULE_04
			if (us_wrap) begin
				value.ms <= (value.ms == FRT_SUB_LAST) ? 10'h000 : value.ms + 10'h001; // RULE_05
			end
			if (ms_wrap) begin
				value.sec <= (value.sec == FRT_SEC_LAST) ? 12'h000 : value.sec + 12'h001; // RULE_06
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ms_tick <= 1'b0;
			sec_tick <= 1'b0;
		end else begin
			ms_tick <= us_wrap && !clear && !load;
			sec_tick <= ms_wrap && !clear && !load;
		end
	end

endmodule // free_running_timer

/* design/timer_unit_pkg.sv */
package timer_unit_pkg;

	// Bus geometry.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// Register byte addresses.
	localparam logic [15:0] OFS_WATCHDOG_SETUP = 16'h1040;
	localparam logic [15:0] OFS_WATCHDOG_SOFTWARE_STATUS = 16'h1044;
	localparam logic [15:0] OFS_FREE_RUNNING_TIME_COUNT = 16'h1048;
	localparam logic [15:0] OFS_INTERVAL_INTERRUPT_TIMER = 16'h104c;
	localparam logic [15:0] OFS_INT_STATUS = 16'h1050;
	localparam logic [15:0] OFS_INT_MASK = 16'h1054;
	localparam logic [15:0] OFS_SOFT_RESET = 16'h1058;

	// Watchdog setup fields.
	localparam int WD_ENABLE_BIT = 0;
	localparam int WD_LOAD_ENABLE_BIT = 1;
	localparam int WD_COUNT_LSB = 16;
	localparam int WATCHDOG_TIMEOUT_SECONDS_LSB = 24;
	localparam logic [7:0] WATCHDOG_TIMEOUT_SECONDS_RESET = 8'h02;

	// Watchdog software status fields.
	localparam int WD_REARM_BIT = 0;
	localparam int FORCE_EXPIRY_BIT = 1;
	localparam int STUCK_REASON_LSB = 24;
	localparam logic [7:0] STUCK_REASON_RESET = 8'h00;

	// Free-running timer fields.
	localparam int FRT_US_LSB = 0;
	localparam int FRT_MS_LSB = 10;
	localparam int FRT_SEC_LSB = 20;
	localparam logic [9:0] FRT_SUB_LAST = 10'h3e7;
	localparam logic [11:0] FRT_SEC_LAST = 12'hfff;

	// Interval timer fields.
	localparam int IVL_DURATION_LSB = 0;
	localparam int IVL_START_BIT = 8;
	localparam int IVL_COUNT_ENABLE_BIT = 9;
	localparam int IVL_FINISH_BIT = 10;
	localparam int IVL_LOOP_BIT = 11;
	localparam logic [7:0] IVL_DURATION_RESET = 8'h00;

	// Interrupt status and mask bits.
	localparam int IRQ_WATCHDOG_BIT = 0;
	localparam int IRQ_INTERVAL_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	// Soft reset register.
	localparam int SOFT_RESET_BIT = 0;

	// Timing.
	localparam int CLK_PERIOD_NS = 20;
	localparam int MICROSECOND_NS = 1000;
	localparam int CYCLES_PER_US = (MICROSECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] PRESCALE_LAST = 6'(CYCLES_PER_US - 1);

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0] byteenable;
	} avl_req_t;

	typedef struct packed {
		logic [11:0] sec;
		logic [9:0] ms;
		logic [9:0] us;
	} frt_value_t;

	typedef enum logic [1:0] {
		IVL_IDLE,
		IVL_RUN,
		IVL_FINISHED
	} ivl_state_t;

endpackage

/* verif/device_timer_unit_tb.sv */
`timescale 1ns/1ns
module device_timer_unit_tb;
	import timer_unit_pkg::*;
	logic ref_clk;
	logic rstn;
	avl_req_t avl_req;
	logic [DATA_W-1:0] avl_readdata;
	logic avl_waitrequest;
	logic irq;
	logic software_definable_pin;
	logic [31:0] rv;
	int err_total;
	int tests_run;

	device_timer_unit u_dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.avl_req(avl_req),
		.avl_readdata(avl_readdata),
		.avl_waitrequest(avl_waitrequest),
		.irq(irq),
		.software_definable_pin(software_definable_pin)
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic close_out;
		$display("compares %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// The request stays up until the edge that samples waitrequest low.
	task automatic xfer(input logic is_wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avl_req.read <= ~is_wr;
		avl_req.write <= is_wr;
		avl_req.address <= a;
		avl_req.writedata <= d;
		avl_req.byteenable <= 4'hf;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avl_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_total++;
			$display("unexpected at %0t: no answer", $time);
		end
		rv = avl_readdata;
		avl_req.read <= 1'b0;
		avl_req.write <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rv & m, e);
	endtask

	// Parks the timer one microsecond short of a millisecond, so a tick lands soon.
	task automatic tick;
		wr(16'h1048, 32'h3e7);
		repeat (80) @(posedge ref_clk);
	endtask

	task automatic sts(input logic [31:0] e);
		rd(16'h1050, 32'h2, e);
		wr(16'h1050, 32'h2);
	endtask

	initial begin
		#200000;
		err_total++;
		close_out();
	end

	initial begin
		err_total = 0;
		tests_run = 0;
		avl_req = '0;
		rstn = 1'b0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(16'h1044, 32'hffffffff, 32'h0);
		rd(16'h1040, 32'hffff0000, 32'h02020000);
		rd(16'h104c, 32'hffffffff, 32'h0);
		wr(16'h1100, 32'hffffffff);
		rd(16'h1100, 32'hffffffff, 32'h0);
		wr(16'h1054, 32'h3);
		wr(16'h1044, 32'h5a000000);
		rd(16'h1044, 32'hffffffff, 32'h5a000000);
		// Force and re-arm together: the expiry must win.
		wr(16'h1044, 32'h5a000003);
		repeat (3) @(posedge ref_clk);
		chk(32'(software_definable_pin), 32'h1);
		chk(32'(irq), 32'h1);
		rd(16'h1040, 32'h00ff0000, 32'h0);
		rd(16'h1044, 32'hffffffff, 32'h5a000000);
		wr(16'h1054, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk(32'(irq), 32'h0);
		rd(16'h1050, 32'h3, 32'h1);
		wr(16'h1050, 32'h1);
		rd(16'h1050, 32'h3, 32'h0);
		wr(16'h1054, 32'h3);
		chk(32'(software_definable_pin), 32'h1);
		wr(16'h1044, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(32'(software_definable_pin), 32'h0);
		rd(16'h1040, 32'h00ff0000, 32'h00020000);
		rd(16'h1044, 32'hffffffff, 32'h0);
		wr(16'h1040, 32'h05000000);
		wr(16'h1044, 32'h1);
		rd(16'h1040, 32'hffff0000, 32'h05050000);
		wr(16'h1048, {12'hfff, 10'h3e7, 10'h3e6});
		rd(16'h1048, 32'hffffffff, {12'hfff, 10'h3e7, 10'h3e6});
		repeat (110) @(posedge ref_clk);
		rd(16'h1048, 32'hffffffff, 32'h0);
		wr(16'h1048, {12'h123, 10'h2a, 10'h0});
		wr(16'h1058, 32'h1);
		rd(16'h1048, 32'hfffffc00, 32'h0);
		wr(16'h104c, 32'ha01);
		tick();
		sts(32'h0);
		wr(16'h104c, 32'hb01);
		tick();
		chk(32'(irq), 32'h1);
		sts(32'h2);
		tick();
		sts(32'h2);
		wr(16'h104c, 32'h801);
		tick();
		sts(32'h0);
		wr(16'h104c, 32'ha01);
		tick();
		sts(32'h2);
		wr(16'h104c, 32'h301);
		tick();
		sts(32'h2);
		tick();
		sts(32'h0);
		wr(16'h104c, 32'h401);
		sts(32'h2);
		rd(16'h104c, 32'hfff, 32'h001);
		wr(16'h104c, 32'ha01);
		tick();
		sts(32'h2);
		// A bus reset in mid-run must clear the timer and bring back the reset timeout.
		wr(16'h1048, {12'h321, 10'h15, 10'h0});
		rstn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(16'h1048, 32'hffffffff, 32'h0);
		rd(16'h1040, 32'hffff0000, 32'h02020000);
		close_out();
	end
endmodule // device_timer_unit_tb

/* verif/timer_unit_monitor.sv */
`timescale 1ns/1ns
module timer_unit_monitor
	import timer_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire timer_unit_pkg::avl_req_t avl_req,
	input wire logic [timer_unit_pkg::DATA_W-1:0] avl_readdata,
	input wire logic avl_waitrequest,
	input wire logic irq,
	input wire logic software_definable_pin
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire take_rd = avl_req.read && !avl_waitrequest;
	wire on_sts = avl_req.write && !avl_waitrequest && avl_req.address == 16'h1044 && avl_req.byteenable[0];
	wire rearm_w = on_sts && avl_req.writedata[0] && !avl_req.writedata[1];
	wire force_w = on_sts && avl_req.writedata[1];
	wire mapped = avl_req.address inside {16'h1040, 16'h1044, 16'h1048, 16'h104c, 16'h1050, 16'h1054, 16'h1058};
	sequence s_force;
		force_w;
	endsequence
	sequence s_rearm;
		rearm_w;
	endsequence
	a_answer_next: assert property ((avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest)
		else $error("request not answered next cycle");
	a_answer_once: assert property (!avl_waitrequest |=> avl_waitrequest)
		else $error("answer lasted over one cycle");
	a_rd_stable: assert property (!avl_req.read |=> $stable(avl_readdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (take_rd && !mapped |-> avl_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_force_pin: assert property (s_force |-> ##[1:2] software_definable_pin)
		else $error("force expiry did not raise pin");
	a_rearm_pin: assert property (s_rearm |-> ##[1:2] !software_definable_pin)
		else $error("re-arm did not drop pin");
	a_pin_hold: assert property (software_definable_pin && !rearm_w && !$past(rearm_w) |=> software_definable_pin)
		else $error("pin dropped without re-arm");
	a_sts_bits: assert property (take_rd && avl_req.address == 16'h1044 |-> avl_readdata[23:0] == 24'h0)
		else $error("status low bits not zero");
	a_ivl_bits: assert property (take_rd && avl_req.address == 16'h104c |->
		avl_readdata[31:12] == 20'h0 && !avl_readdata[10] && !avl_readdata[8])
		else $error("interval write-only bits not zero");
endmodule // timer_unit_monitor

bind device_timer_unit timer_unit_monitor u_mon (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.avl_req(avl_req),
	.avl_readdata(avl_readdata),
	.avl_waitrequest(avl_waitrequest),
	.irq(irq),
	.software_definable_pin(software_definable_pin)
);
